// ### src/lmf_mem.sv
`default_nettype none

package lmf_pkg;
    localparam int LMF_DEPTH = 5120;
    localparam int LMF_DW = 8;
    localparam int LMF_AW = 13;
    localparam int LMF_SETUP_BITS = 13;
    localparam logic [12:0] LMF_FIRST = 13'h0000;
    localparam logic [12:0] LMF_LAST = 13'h13ff;
    // Bit positions of the sampled pin vector; data sits above the controls.
    localparam int LMF_IX_WCLK = 0;
    localparam int LMF_IX_WEN = 1;
    localparam int LMF_IX_WRITE_RESET_N = 2;
    localparam int LMF_IX_RCLK = 3;
    localparam int LMF_IX_REN = 4;
    localparam int LMF_IX_READ_RESET_N = 5;
    localparam int LMF_IX_SCLK = 6;
    localparam int LMF_IX_CMD = 7;
    localparam int LMF_IX_MAS = 8;
    localparam int LMF_IX_SA = 9;
    localparam int LMF_IX_DATA = 10;
    localparam int LMF_CTRL_PINS = 10;
    typedef enum logic [0:0] {
        LMF_LIFO = 1'b0,
        LMF_FIFO = 1'b1
    } lmf_mode_t;
    localparam lmf_mode_t LMF_MODE_RST = LMF_FIFO;
    localparam logic [3:0] LMF_NBITS_RST = 4'h0;
    localparam logic LMF_OE_N_RST = 1'b1;
    localparam logic [7:0] LMF_Q_RST = 8'h00;
endpackage

module lmf_mem #(
    parameter int DEPTH = lmf_pkg::LMF_DEPTH,
    parameter int DW = lmf_pkg::LMF_DW,
    parameter int AW = lmf_pkg::LMF_AW
) (
    input wire logic clk_sys,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    // The line store itself; one write and one registered read per cycle.
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

`default_nettype wire

// ### src/lmf_line_mem.sv
// The plain strobed port and the register addresses are this design's own decisions.
`default_nettype none

// Contract
// - Enabled write clock rise stores the byte, steps the write counter.
// - Write enable high: no store, write counter holds.
// - Write reset low at write clock rise reinitializes the write counter.
// - Enabled read clock rise outputs the byte, steps the read counter.
// - Read enable high: no read, counter holds, output floats.
// - Read reset low at read clock rise reinitializes the read counter.
// - Setup input counts only while command enable is low.
// - Mode select high: setup bit at shift clock rise picks FIFO or LIFO.
// - Mode select low: setup bits shift in to form the read start address.
// - New mode takes effect at the next write and read resets.
// - FIFO write reset goes to zero, then writes count upward.
// - FIFO read reset goes to zero or start address, then reads count up.
// - LIFO resets go to 0 or 5119, read to m or 5119-m.
// - LIFO resets alternate start between 0 upward and 5119 downward.
// - Command high, read reset low: read counter loads the start address.
// - Start address used only with load enable low; high ignores it.
// - Command high, system reset low, both resets: FIFO, no start, zero.
// - Store holds 5120 bytes, addresses 0 to 5119.
module lmf_line_mem #(
    parameter int DEPTH = lmf_pkg::LMF_DEPTH,
    parameter int DW = lmf_pkg::LMF_DW,
    parameter int AW = lmf_pkg::LMF_AW
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic write_clock_in,
    input wire logic write_enable_n,
    input wire logic write_reset_n,
    input wire logic [DW-1:0] write_data_in,
    input wire logic read_clock_in,
    input wire logic read_enable_n,
    input wire logic read_reset_n,
    input wire logic serial_shift_clock,
    input wire logic command_enable_n,
    input wire logic mode_address_select,
    input wire logic serial_setup_in,
    output logic [DW-1:0] read_data_out,
    output logic read_data_oe_n
);
    localparam int PW = lmf_pkg::LMF_CTRL_PINS + DW;

    if (DEPTH != lmf_pkg::LMF_DEPTH || AW != lmf_pkg::LMF_AW) begin : g_chk
        $error("Counter limits are fixed at 5120 words and 13 bits.");
    end
    if (DW < 1) begin : g_chk_dw
        $error("Data width must be at least one bit.");
    end

    typedef struct packed {
        logic [PW-1:0] s1;
        logic [PW-1:0] s2;
        logic [PW-1:0] s3;
        logic [PW-1:0] f;
        lmf_pkg::lmf_mode_t pend_mode;
        logic [AW-1:0] shift;
        logic [3:0] nbits;
        logic [AW-1:0] start;
        logic start_ok;
        lmf_pkg::lmf_mode_t wr_mode;
        lmf_pkg::lmf_mode_t rd_mode;
        logic wr_down;
        logic rd_down;
        logic wr_tog;
        logic rd_tog;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic rd_pend;
        logic [DW-1:0] q;
        logic oe_n;
    } lmf_state_t;

    lmf_state_t st_q;
    lmf_state_t st_d;
    logic [PW-1:0] pins;
    logic [PW-1:0] g;
    logic wr_edge;
    logic rd_edge;
    logic sh_edge;
    logic cmd_rise;
    logic wr_go;
    logic wr_init;
    logic wr_sys;
    logic rd_go;
    logic rd_init;
    logic rd_sys;
    logic rd_use_start;
    logic mem_we;
    logic mem_re;
    logic [AW-1:0] mem_raddr;
    logic [DW-1:0] mem_rdata;
    lmf_pkg::lmf_mode_t wr_pick;
    lmf_pkg::lmf_mode_t rd_pick;

    // Next counter value; both ends wrap around the 5120-word store.
    function automatic logic [AW-1:0] lmf_step(input logic [AW-1:0] ptr,
                                               input logic down);
        logic [AW-1:0] nxt;
        nxt = ptr;
        if (down) begin
            nxt = (ptr == lmf_pkg::LMF_FIRST) ? lmf_pkg::LMF_LAST
                                              : ptr - AW'(1);
        end else begin
            nxt = (ptr == lmf_pkg::LMF_LAST) ? lmf_pkg::LMF_FIRST
                                             : ptr + AW'(1);
        end
        return nxt;
    endfunction

    assign pins = {write_data_in, serial_setup_in, mode_address_select,
                   command_enable_n, serial_shift_clock, read_reset_n,
                   read_enable_n, read_clock_in, write_reset_n,
                   write_enable_n, write_clock_in};

    always_comb begin
        st_d = st_q;
        // Three-stage sampling; a level counts once stages two and three agree.
        st_d.s1 = pins;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.f = (~(st_q.s2 ^ st_q.s3) & st_q.s3)
               | ((st_q.s2 ^ st_q.s3) & st_q.f);
        g = st_d.f;
        wr_edge = g[lmf_pkg::LMF_IX_WCLK] & ~st_q.f[lmf_pkg::LMF_IX_WCLK];
        rd_edge = g[lmf_pkg::LMF_IX_RCLK] & ~st_q.f[lmf_pkg::LMF_IX_RCLK];
        sh_edge = g[lmf_pkg::LMF_IX_SCLK] & ~st_q.f[lmf_pkg::LMF_IX_SCLK];
        cmd_rise = g[lmf_pkg::LMF_IX_CMD] & ~st_q.f[lmf_pkg::LMF_IX_CMD];

        // Setup port, live only during an instruction cycle.
        if (!g[lmf_pkg::LMF_IX_CMD] && sh_edge) begin
            if (g[lmf_pkg::LMF_IX_MAS]) begin
                st_d.pend_mode = g[lmf_pkg::LMF_IX_SA]
                               ? lmf_pkg::LMF_FIFO : lmf_pkg::LMF_LIFO;
            end else begin
                st_d.shift = {st_q.shift[AW-2:0],
                              g[lmf_pkg::LMF_IX_SA]};
                if (st_q.nbits != 4'(lmf_pkg::LMF_SETUP_BITS)) begin
                    st_d.nbits = st_q.nbits + 4'h1;
                end
            end
        end

        // Write port.
        wr_init = wr_edge && !g[lmf_pkg::LMF_IX_WRITE_RESET_N];
        wr_go = wr_edge && g[lmf_pkg::LMF_IX_WRITE_RESET_N]
              && !g[lmf_pkg::LMF_IX_WEN];
        wr_sys = wr_init && g[lmf_pkg::LMF_IX_CMD]
               && !g[lmf_pkg::LMF_IX_SA];
        wr_pick = g[lmf_pkg::LMF_IX_CMD] ? st_q.pend_mode : st_q.wr_mode;
        mem_we = wr_go;
        if (wr_sys) begin
            st_d.pend_mode = lmf_pkg::LMF_FIFO;
            st_d.start_ok = 1'b0;
            st_d.wr_mode = lmf_pkg::LMF_FIFO;
            st_d.wr_ptr = lmf_pkg::LMF_FIRST;
            st_d.wr_down = 1'b0;
            st_d.wr_tog = 1'b0;
        end else if (wr_init) begin
            st_d.wr_mode = wr_pick;
            if (wr_pick == lmf_pkg::LMF_FIFO) begin
                st_d.wr_ptr = lmf_pkg::LMF_FIRST;
                st_d.wr_down = 1'b0;
                st_d.wr_tog = 1'b0;
            end else begin
                st_d.wr_ptr = st_q.wr_tog ? lmf_pkg::LMF_LAST
                                          : lmf_pkg::LMF_FIRST;
                st_d.wr_down = st_q.wr_tog;
                st_d.wr_tog = ~st_q.wr_tog;
            end
        end else if (wr_go) begin
            st_d.wr_ptr = lmf_step(st_q.wr_ptr, st_q.wr_down);
        end

        // Read port.
        rd_init = rd_edge && !g[lmf_pkg::LMF_IX_READ_RESET_N];
        rd_go = rd_edge && g[lmf_pkg::LMF_IX_READ_RESET_N]
              && !g[lmf_pkg::LMF_IX_REN];
        rd_sys = rd_init && g[lmf_pkg::LMF_IX_CMD]
               && !g[lmf_pkg::LMF_IX_SA];
        rd_pick = g[lmf_pkg::LMF_IX_CMD] ? st_q.pend_mode : st_q.rd_mode;
        rd_use_start = g[lmf_pkg::LMF_IX_CMD] && st_q.start_ok
                     && !g[lmf_pkg::LMF_IX_MAS];
        mem_re = rd_go;
        mem_raddr = st_q.rd_ptr;
        st_d.rd_pend = rd_go;
        if (rd_sys) begin
            st_d.pend_mode = lmf_pkg::LMF_FIFO;
            st_d.start_ok = 1'b0;
            st_d.rd_mode = lmf_pkg::LMF_FIFO;
            st_d.rd_ptr = lmf_pkg::LMF_FIRST;
            st_d.rd_down = 1'b0;
            st_d.rd_tog = 1'b0;
        end else if (rd_init) begin
            st_d.rd_mode = rd_pick;
            st_d.rd_ptr = rd_use_start ? st_q.start
                                       : lmf_pkg::LMF_FIRST;
            st_d.rd_down = 1'b0;
            if (rd_pick == lmf_pkg::LMF_FIFO) begin
                st_d.rd_tog = 1'b0;
            end else begin
                if (st_q.rd_tog) begin
                    st_d.rd_ptr = lmf_pkg::LMF_LAST
                                - (rd_use_start ? st_q.start
                                                : lmf_pkg::LMF_FIRST);
                end
                st_d.rd_down = st_q.rd_tog;
                st_d.rd_tog = ~st_q.rd_tog;
            end
        end else if (rd_go) begin
            st_d.rd_ptr = lmf_step(st_q.rd_ptr, st_q.rd_down);
        end
        if (st_q.rd_pend) begin
            st_d.q = mem_rdata;
        end
        st_d.oe_n = g[lmf_pkg::LMF_IX_REN];

        // Closing the instruction cycle keeps the last full address.
        if (cmd_rise) begin
            st_d.nbits = lmf_pkg::LMF_NBITS_RST;
            if (st_q.nbits == 4'(lmf_pkg::LMF_SETUP_BITS)) begin
                st_d.start = (st_q.shift > lmf_pkg::LMF_LAST)
                           ? lmf_pkg::LMF_LAST : st_q.shift;
                st_d.start_ok = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_q <= '0;
            st_q.pend_mode <= lmf_pkg::LMF_MODE_RST;
            st_q.wr_mode <= lmf_pkg::LMF_MODE_RST;
            st_q.rd_mode <= lmf_pkg::LMF_MODE_RST;
            st_q.nbits <= lmf_pkg::LMF_NBITS_RST;
            st_q.q <= lmf_pkg::LMF_Q_RST;
            st_q.oe_n <= lmf_pkg::LMF_OE_N_RST;
            st_q.f <= {PW{1'b1}};
            st_q.s1 <= {PW{1'b1}};
            st_q.s2 <= {PW{1'b1}};
            st_q.s3 <= {PW{1'b1}};
        end else begin
            st_q <= st_d;
        end
    end

    lmf_mem #(
        .DEPTH(DEPTH),
        .DW(DW),
        .AW(AW)
    ) u_mem (
        .clk_sys(clk_sys),
        .wr_en(mem_we),
        .wr_addr(st_q.wr_ptr),
        .wr_data(g[lmf_pkg::LMF_IX_DATA +: DW]),
        .rd_en(mem_re),
        .rd_addr(mem_raddr),
        .rd_data(mem_rdata)
    );

    assign read_data_out = st_q.q;
    assign read_data_oe_n = st_q.oe_n;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    sequence s_read_issue;
        rd_go;
    endsequence
    sequence s_read_land;
        ##2 (read_data_out == $past(mem_rdata));
    endsequence

    property p_wr_step;
        wr_go |=> (st_q.wr_ptr != $past(st_q.wr_ptr));
    endproperty
    a_wr_step: assert property (p_wr_step)
        else $error("Write counter did not step on an enabled write.");

    property p_wr_hold;
        (!wr_go && !wr_init) |=> $stable(st_q.wr_ptr);
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("Write counter moved without an enabled write.");

    property p_wr_fifo_init;
        (wr_init && wr_pick == lmf_pkg::LMF_FIFO)
            |=> (st_q.wr_ptr == lmf_pkg::LMF_FIRST && !st_q.wr_down);
    endproperty
    a_wr_fifo_init: assert property (p_wr_fifo_init)
        else $error("FIFO write reset did not start at zero upward.");

    property p_rd_data;
        s_read_issue |-> s_read_land;
    endproperty
    a_rd_data: assert property (p_rd_data)
        else $error("Read byte did not reach the output two cycles later.");

    property p_rd_float;
        (st_d.f[lmf_pkg::LMF_IX_REN] && !rd_init) |=>
            (read_data_oe_n && $stable(st_q.rd_ptr));
    endproperty
    a_rd_float: assert property (p_rd_float)
        else $error("Output driven or counter moved with read disabled.");

    property p_mode_set;
        (sh_edge && !g[lmf_pkg::LMF_IX_CMD] && g[lmf_pkg::LMF_IX_MAS])
            |=> (st_q.pend_mode == $past(g[lmf_pkg::LMF_IX_SA]));
    endproperty
    a_mode_set: assert property (p_mode_set)
        else $error("Mode bit not taken at the shift clock rise.");

    property p_sys_reset;
        wr_sys |=> (st_q.wr_ptr == lmf_pkg::LMF_FIRST && !st_q.start_ok
                    && st_q.wr_mode == lmf_pkg::LMF_FIFO);
    endproperty
    a_sys_reset: assert property (p_sys_reset)
        else $error("System reset did not restore FIFO at address zero.");

    property p_lifo_top;
        (wr_init && !wr_sys && wr_pick == lmf_pkg::LMF_LIFO && st_q.wr_tog)
            |=> (st_q.wr_ptr == lmf_pkg::LMF_LAST && st_q.wr_down
                 && !st_q.wr_tog);
    endproperty
    a_lifo_top: assert property (p_lifo_top)
        else $error("LIFO reset did not alternate to the top downward.");

    property p_start_load;
        (cmd_rise && st_q.nbits == 4'(lmf_pkg::LMF_SETUP_BITS))
            |=> st_q.start_ok;
    endproperty
    a_start_load: assert property (p_start_load)
        else $error("Full start address was not retained.");

    property p_start_apply;
        (rd_init && !rd_sys && rd_use_start && rd_pick == lmf_pkg::LMF_FIFO)
            |=> (st_q.rd_ptr == $past(st_q.start));
    endproperty
    a_start_apply: assert property (p_start_apply)
        else $error("Read reset ignored the stored start address.");
endmodule

`default_nettype wire

// ### testbench/lmf_far_end.sv
`default_nettype none

// Writer, reader and setup controller on the pin side of the line memory.
// Clock and strobed levels are held for at least four system clocks; the idle data, enable and reset levels between strobes can last one.
module lmf_far_end (
    input wire logic clk_sys,
    output logic write_clock_in,
    output var logic write_enable_n,
    output var logic write_reset_n,
    output var logic [7:0] write_data_in,
    output logic read_clock_in,
    output var logic read_enable_n,
    output var logic read_reset_n,
    output logic serial_shift_clock,
    output var logic command_enable_n,
    output var logic mode_address_select,
    output var logic serial_setup_in
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [2:0] ck_q;

    assign write_clock_in = ck_q[0];
    assign read_clock_in = ck_q[1];
    assign serial_shift_clock = ck_q[2];

    initial begin
        ck_q = 3'h0;
        write_enable_n = 1'b1;
        write_reset_n = 1'b1;
        write_data_in = 8'h00;
        read_enable_n = 1'b1;
        read_reset_n = 1'b1;
        command_enable_n = 1'b1;
        mode_address_select = 1'b0;
        serial_setup_in = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic pulse(input int i);
        tick(4);
        ck_q <= ck_q | (3'h1 << i);
        tick(4);
        ck_q <= ck_q & ~(3'h1 << i);
    endtask

    task automatic wr(input logic [7:0] d, input logic en_n,
                      input logic rs_n);
        write_data_in <= d;
        write_enable_n <= en_n;
        write_reset_n <= rs_n;
        pulse(0);
        write_data_in <= ~d;
        write_enable_n <= 1'b1;
        write_reset_n <= 1'b1;
        tick(1);
    endtask

    task automatic rd(input logic en_n, input logic rs_n);
        read_enable_n <= en_n;
        read_reset_n <= rs_n;
        pulse(1);
        tick(4);
        read_enable_n <= 1'b1;
        read_reset_n <= 1'b1;
        tick(1);
    endtask

    task automatic setup(input logic sel, input logic [12:0] v, input int n,
                         input logic cmd_n);
        command_enable_n <= cmd_n;
        mode_address_select <= sel;
        for (int i = n - 1; i >= 0; i--) begin
            serial_setup_in <= v[i];
            pulse(2);
        end
        tick(4);
        command_enable_n <= 1'b1;
        mode_address_select <= 1'b0;
        serial_setup_in <= 1'b1;
        tick(4);
    endtask

    task automatic pins(input logic system_reset_n_n, input logic load_address_enable);
        serial_setup_in <= system_reset_n_n;
        mode_address_select <= load_address_enable;
        tick(4);
    endtask
endmodule

`default_nettype wire

// ### testbench/lmf_line_mem_bench.sv
`default_nettype none

module lmf_line_mem_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_sys;
    logic reset_n;
    logic write_clock_in, write_enable_n, write_reset_n;
    logic read_clock_in, read_enable_n, read_reset_n, read_data_oe_n;
    logic serial_shift_clock, command_enable_n;
    logic mode_address_select, serial_setup_in;
    logic [7:0] write_data_in, read_data_out;
    int err_total;
    int n_checks;

    lmf_far_end u_far (.clk_sys(clk_sys),
        .write_clock_in(write_clock_in), .write_enable_n(write_enable_n),
        .write_reset_n(write_reset_n), .write_data_in(write_data_in),
        .read_clock_in(read_clock_in), .read_enable_n(read_enable_n),
        .read_reset_n(read_reset_n), .serial_shift_clock(serial_shift_clock),
        .command_enable_n(command_enable_n),
        .mode_address_select(mode_address_select),
        .serial_setup_in(serial_setup_in));

    lmf_line_mem i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .write_clock_in(write_clock_in), .write_enable_n(write_enable_n),
        .write_reset_n(write_reset_n), .write_data_in(write_data_in),
        .read_clock_in(read_clock_in), .read_enable_n(read_enable_n),
        .read_reset_n(read_reset_n), .serial_shift_clock(serial_shift_clock),
        .command_enable_n(command_enable_n),
        .mode_address_select(mode_address_select),
        .serial_setup_in(serial_setup_in), .read_data_out(read_data_out),
        .read_data_oe_n(read_data_oe_n));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic en_n, input logic [7:0] exp);
        u_far.rd(en_n, 1'b1);
        chk("read_data_out", read_data_out, exp);
        chk("read_data_oe_n", {7'h00, read_data_oe_n}, {7'h00, en_n});
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys);
        err_total++;
        report_and_stop();
    end

    initial begin
        err_total = 0;
        n_checks = 0;
        reset_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        u_far.tick(4);
        chk("read_data_oe_n", {7'h00, read_data_oe_n}, 8'h01);
        u_far.wr(8'h00, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            u_far.wr(8'h30 + i[7:0], 1'b0, 1'b1);
        end
        u_far.rd(1'b0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            rd_chk(1'b0, 8'h30 + i[7:0]);
        end
        $display("test fifo_order done");
        u_far.wr(8'h00, 1'b0, 1'b0);
        u_far.wr(8'h41, 1'b0, 1'b1);
        u_far.wr(8'h5a, 1'b1, 1'b1);
        u_far.wr(8'h42, 1'b0, 1'b1);
        u_far.rd(1'b0, 1'b0);
        rd_chk(1'b0, 8'h41);
        rd_chk(1'b1, 8'h41);
        rd_chk(1'b0, 8'h42);
        $display("test enables done");
        u_far.setup(1'b0, 13'h0002, 13, 1'b0);
        u_far.setup(1'b0, 13'h1fff, 13, 1'b1);
        u_far.wr(8'h00, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            u_far.wr(8'h60 + i[7:0], 1'b0, 1'b1);
        end
        u_far.rd(1'b0, 1'b0);
        rd_chk(1'b0, 8'h62);
        rd_chk(1'b0, 8'h63);
        u_far.pins(1'b1, 1'b1);
        u_far.rd(1'b0, 1'b0);
        u_far.pins(1'b1, 1'b0);
        rd_chk(1'b0, 8'h60);
        $display("test start_address done");
        u_far.pins(1'b0, 1'b0);
        u_far.wr(8'h00, 1'b0, 1'b0);
        u_far.rd(1'b0, 1'b0);
        u_far.pins(1'b1, 1'b0);
        u_far.wr(8'h70, 1'b0, 1'b1);
        u_far.rd(1'b0, 1'b0);
        rd_chk(1'b0, 8'h70);
        rd_chk(1'b0, 8'h61);
        $display("test system_reset done");
        u_far.setup(1'b1, 13'h0000, 1, 1'b0);
        u_far.wr(8'h00, 1'b0, 1'b0);
        for (int i = 0; i < 3; i++) begin
            u_far.wr(8'h80 + i[7:0], 1'b0, 1'b1);
        end
        u_far.wr(8'h00, 1'b0, 1'b0);
        for (int i = 0; i < 3; i++) begin
            u_far.wr(8'h90 + i[7:0], 1'b0, 1'b1);
        end
        u_far.rd(1'b0, 1'b0);
        for (int i = 0; i < 3; i++) begin
            rd_chk(1'b0, 8'h80 + i[7:0]);
        end
        u_far.rd(1'b0, 1'b0);
        for (int i = 0; i < 3; i++) begin
            rd_chk(1'b0, 8'h90 + i[7:0]);
        end
        u_far.setup(1'b0, 13'h0001, 13, 1'b0);
        u_far.rd(1'b0, 1'b0);
        for (int i = 0; i < 2; i++) begin
            rd_chk(1'b0, 8'h81 + i[7:0]);
        end
        u_far.rd(1'b0, 1'b0);
        for (int i = 0; i < 2; i++) begin
            rd_chk(1'b0, 8'h91 + i[7:0]);
        end
        $display("test lifo done");
        u_far.setup(1'b1, 13'h0001, 1, 1'b0);
        u_far.wr(8'h00, 1'b0, 1'b0);
        u_far.wr(8'ha0, 1'b0, 1'b1);
        u_far.wr(8'ha1, 1'b0, 1'b1);
        u_far.rd(1'b0, 1'b0);
        rd_chk(1'b0, 8'ha1);
        $display("test fifo_return done");
        u_far.setup(1'b1, 13'h0000, 1, 1'b0);
        u_far.pins(1'b0, 1'b0);
        u_far.wr(8'h00, 1'b0, 1'b0);
        u_far.rd(1'b0, 1'b0);
        u_far.pins(1'b1, 1'b0);
        u_far.wr(8'h00, 1'b0, 1'b0);
        u_far.wr(8'h00, 1'b0, 1'b0);
        u_far.wr(8'hb0, 1'b0, 1'b1);
        u_far.rd(1'b0, 1'b0);
        rd_chk(1'b0, 8'hb0);
        $display("test mode_restore done");
        report_and_stop();
    end
endmodule

`default_nettype wire
